/* dv/iesw_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none
// far-end counter: 4-fold evaluation of both channels
module iesw_rx_model (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic a_i,
  input wire logic b_i,
  output logic [15:0] pos_o,
  output logic miss_o
);
  logic [1:0] s1, s2, prev;

  // forward successor in the order 00,10,11,01
  function automatic logic [1:0] succ(input logic [1:0] x);
    case (x)
      2'h0: return 2'h2;
      2'h2: return 2'h3;
      2'h3: return 2'h1;
      default: return 2'h0;
    endcase
  endfunction

  // two flops per line; sampling every cycle leaves margin below 90 percent spacing
  always_ff @(posedge sys_clk_i) begin
    s1 <= {a_i, b_i};
    s2 <= s1;
  end

  // each edge is one step; a double change means an edge was lost
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      prev <= 2'h0;
      pos_o <= 16'h0;
      miss_o <= 1'b0;
    end else begin
      prev <= s2;
      if (s2 == succ(prev)) pos_o <= pos_o + 16'h1;
      else if (prev == succ(s2)) pos_o <= pos_o - 16'h1;
      else if (s2 != prev) miss_o <= 1'b1;
    end
  end
endmodule // iesw_rx_model
`default_nettype wire

/* dv/incremental_square_wave_encoder_link_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "iesw_regs.svh"
module incremental_square_wave_encoder_link_tb_top;
  localparam int FMIN = 50;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic step_i = 1'b0, dir_i = 1'b0, ref_i = 1'b0, fault_i = 1'b0;
  logic north_i = 1'b0, south_i = 1'b0, variant_i = 1'b0;
  logic [1:0] pat = 2'h0;
  iesw_pkg::iesw_incr_t incr;
  iesw_pkg::iesw_comm_t comm;
  logic fault_n, lim1, lim2, miss;
  logic [15:0] pos, exp_pos;
  integer seed = 32'h56a0;
  int error_cnt = 0;
  int compares = 0;
  int n, h;

  // free-running 50 MHz clock
  initial forever #10 sys_clk_i = ~sys_clk_i;

  iesw_encoder_out #(.FAULT_MIN_CYC(FMIN)) dut_u (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .step_i(step_i), .dir_i(dir_i),
    .ref_track_i(ref_i), .light_fault_i(fault_i), .north_magnet_i(north_i),
    .south_magnet_i(south_i), .single_ended_high_voltage_variant_i(variant_i),
    .comm_pattern_i(pat), .incr_o(incr), .comm_o(comm), .fault_detect_n_o(fault_n),
    .first_limit_output_o(lim1), .second_limit_output_o(lim2));

  iesw_rx_model rx_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .a_i(incr.a),
    .b_i(incr.b), .pos_o(pos), .miss_o(miss));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // inputs always move 2 ns after the edge
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #2;
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // steps per half commutation period for each pattern code
  function automatic int half(input logic [1:0] p);
    case (p)
      2'h1: return `IESW_PER_3 / 2;
      2'h2: return `IESW_PER_4 / 2;
      default: return `IESW_PER_2 / 2;
    endcase
  endfunction

  task automatic do_reset(input logic [1:0] p);
    reset_n_i = 1'b0;
    pat = p;
    tick(6);
    reset_n_i = 1'b1;
    tick(4);
    exp_pos = 16'h0;
    chk(fault_n, 1'b1);
    chk({comm.u, comm.v, comm.w}, 3'h5);
  endtask

  task automatic chk_outs();
    chk(incr.a_n, variant_i ? 1'b0 : !incr.a);
    chk(incr.b_n, variant_i ? 1'b0 : !incr.b);
    chk(incr.refp, ref_i & incr.a & incr.b);
    chk(incr.refp_n, variant_i ? 1'b0 : !incr.refp);
    chk(pos, exp_pos);
    chk({comm.u_n, comm.v_n, comm.w_n}, {!comm.u, !comm.v, !comm.w});
  endtask

  // one step, then wait past the 10-cycle spacing
  task automatic step(input logic d, input logic r);
    step_i = 1'b1;
    dir_i = d;
    ref_i = r;
    tick(1);
    step_i = 1'b0;
    tick(11);
    exp_pos = d ? exp_pos + 16'h1 : exp_pos - 16'h1;
    chk_outs();
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    error_cnt++;
    finish_test();
  end

  // main sequence
  initial begin
    do_reset(2'h0);
    for (int i = 0; i < 200; i++) begin
      if (i == 120) variant_i = 1'b1;
      step(1'($random(seed)), 1'($random(seed)));
    end
    // three pulses back to back: one taken, one held, one dropped
    step_i = 1'b1;
    dir_i = 1'b1;
    tick(3);
    step_i = 1'b0;
    tick(30);
    exp_pos = exp_pos + 16'h2;
    chk_outs();
    // fault held for 1 and for 7 cycles
    // the minimum low time restarts every cycle the pin is held, so low lasts FMIN + l - 1 cycles
    for (int l = 1; l < 8; l += 6) begin
      fault_i = 1'b1;
      n = 0;
      for (int i = 0; i < FMIN + 20; i++) begin
        tick(1);
        if (i == l - 1) fault_i = 1'b0;
        if (fault_n === 1'b0) n++;
      end
      chk(n[15:0], 16'(FMIN + l - 1));
    end
    north_i = 1'b1;
    tick(2);
    chk({lim1, lim2}, 2'h0);
    tick(1);
    chk({lim1, lim2}, 2'h2);
    north_i = 1'b0;
    south_i = 1'b1;
    tick(3);
    chk({lim1, lim2}, 2'h1);
    chk(miss, 1'b0);
    for (int p = 0; p < 4; p++) begin
      do_reset(p[1:0]);
      h = half(p[1:0]);
      repeat (h - 1) step(1'b1, 1'b1);
      chk({comm.u, comm.v, comm.w}, 3'h6);
      step(1'b1, 1'b0);
      chk({comm.u, comm.v, comm.w}, 3'h2);
    end
    finish_test();
  end
endmodule // incremental_square_wave_encoder_link_tb_top
`default_nettype wire

/* pkg/iesw_pkg.sv */
`default_nettype none
`include "iesw_regs.svh"

package iesw_pkg;

  // quadrature phase, gray sequence a/b = 00,10,11,01
  typedef enum logic [1:0] {
    IESW_PH0 = 2'h0,
    IESW_PH1 = 2'h1,
    IESW_PH2 = 2'h2,
    IESW_PH3 = 2'h3
  } iesw_quad_ph_t;

  // block commutation pattern per revolution
  typedef enum logic [1:0] {
    IESW_POLE2 = 2'h0,
    IESW_POLE3 = 2'h1,
    IESW_POLE4 = 2'h2,
    IESW_POLE_RSVD = 2'h3
  } iesw_comm_pat_t;

  typedef struct packed {
    logic a;
    logic a_n;
    logic b;
    logic b_n;
    logic refp;
    logic refp_n;
  } iesw_incr_t;

  typedef struct packed {
    logic u;
    logic u_n;
    logic v;
    logic v_n;
    logic w;
    logic w_n;
  } iesw_comm_t;

  typedef struct packed {
    logic [`IESW_SYNC_W-1:0] sync1;
    logic [`IESW_SYNC_W-1:0] sync2;
    iesw_quad_ph_t ph;
    logic [`IESW_HOLD_W-1:0] hold;
    logic pend;
    logic pend_up;
    logic [`IESW_ELEC_W-1:0] elec;
    logic [`IESW_FAULT_W-1:0] fault_cnt;
    logic fault_n;
    iesw_incr_t incr;
    iesw_comm_t comm;
    logic lim1;
    logic lim2;
  } iesw_state_t;

endpackage

`default_nettype wire

/* pkg/iesw_regs.svh */
`ifndef IESW_REGS_SVH
`define IESW_REGS_SVH

// clock and timing figures, times in ns
`define IESW_CLK_PERIOD_NS 20
`define IESW_MIN_EDGE_NS 200
`define IESW_FAULT_MIN_NS 20000000

// field widths of the state record
`define IESW_SYNC_W 7
`define IESW_HOLD_W 4
`define IESW_ELEC_W 10
`define IESW_FAULT_W 20

// bit positions inside the pin synchroniser vector
`define IESW_SB_FAULT 0
`define IESW_SB_REF 1
`define IESW_SB_NORTH 2
`define IESW_SB_SOUTH 3
`define IESW_SB_VARIANT 4
`define IESW_SB_PAT_LO 5
`define IESW_SB_PAT_HI 6

// steps per electrical commutation period and a third of it
`define IESW_PER_2 10'h168
`define IESW_PER_3 10'h0f0
`define IESW_PER_4 10'h0b4
`define IESW_THIRD_2 10'h078
`define IESW_THIRD_3 10'h050
`define IESW_THIRD_4 10'h03c

`endif

/* rtl/iesw_encoder_out.sv */
`timescale 1ns/100ps
`default_nettype none
`include "iesw_regs.svh"

module iesw_encoder_out #(
  parameter int FAULT_MIN_CYC =
    (`IESW_FAULT_MIN_NS + `IESW_CLK_PERIOD_NS - 1) / `IESW_CLK_PERIOD_NS
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic ref_track_i,
  input wire logic light_fault_i,
  input wire logic north_magnet_i,
  input wire logic south_magnet_i,
  input wire logic single_ended_high_voltage_variant_i,
  input wire logic [1:0] comm_pattern_i,
  output iesw_pkg::iesw_incr_t incr_o,
  output iesw_pkg::iesw_comm_t comm_o,
  output logic fault_detect_n_o,
  output logic first_limit_output_o,
  output logic second_limit_output_o
);

  // least spacing between two output edges, rounded up to cycles
  localparam int EDGE_CYC =
    (`IESW_MIN_EDGE_NS + `IESW_CLK_PERIOD_NS - 1) / `IESW_CLK_PERIOD_NS;

  iesw_pkg::iesw_state_t st;
  iesw_pkg::iesw_state_t next_st;
  iesw_pkg::iesw_comm_pat_t pat;
  logic [`IESW_ELEC_W-1:0] per;
  logic [`IESW_ELEC_W-1:0] third;
  logic accept;
  logic move_up;
  logic variant;

  // electrical period length for the selected pattern
  function automatic logic [`IESW_ELEC_W-1:0] elec_period(input iesw_pkg::iesw_comm_pat_t p);
    case (p)
      iesw_pkg::IESW_POLE3: elec_period = `IESW_PER_3;
      iesw_pkg::IESW_POLE4: elec_period = `IESW_PER_4;
      default: elec_period = `IESW_PER_2;
    endcase
  endfunction

  function automatic logic [`IESW_ELEC_W-1:0] elec_third(input iesw_pkg::iesw_comm_pat_t p);
    case (p)
      iesw_pkg::IESW_POLE3: elec_third = `IESW_THIRD_3;
      iesw_pkg::IESW_POLE4: elec_third = `IESW_THIRD_4;
      default: elec_third = `IESW_THIRD_2;
    endcase
  endfunction

  // one track: high in the first half of its shifted period
  function automatic logic comm_bit(input logic [`IESW_ELEC_W-1:0] pos,
                                    input logic [`IESW_ELEC_W-1:0] off,
                                    input logic [`IESW_ELEC_W-1:0] p);
    logic [`IESW_ELEC_W:0] s;
    s = {1'b0, pos} + {1'b0, off};
    if (s >= {1'b0, p}) begin
      s = s - {1'b0, p};
    end
    comm_bit = (s < {2'h0, p[`IESW_ELEC_W-1:1]});
  endfunction

  // unknown pattern code falls back to two periods per turn
  assign pat = iesw_pkg::iesw_comm_pat_t'(st.sync2[`IESW_SB_PAT_HI:`IESW_SB_PAT_LO]);
  assign per = elec_period(pat);
  assign third = elec_third(pat);
  assign variant = st.sync2[`IESW_SB_VARIANT];

  // whole next state in one place
  always_comb begin
    next_st = st;
    // pins pass two flops; only sync2 is ever read
    next_st.sync1 = {comm_pattern_i, single_ended_high_voltage_variant_i, south_magnet_i,
                     north_magnet_i, ref_track_i, light_fault_i};
    next_st.sync2 = st.sync1;

    // edge spacing guard; one step may wait, more are dropped
    move_up = st.pend ? st.pend_up : dir_i;
    accept = (st.pend | step_i) && (st.hold == '0);
    if (st.hold != '0) begin
      next_st.hold = st.hold - `IESW_HOLD_W'(1);
    end
    if (accept) begin
      next_st.hold = `IESW_HOLD_W'(EDGE_CYC - 1);
      next_st.pend = st.pend & step_i;
      next_st.pend_up = dir_i;
      // forward walks 00,10,11,01 so b lags a
      if (move_up) begin
        next_st.ph = iesw_pkg::iesw_quad_ph_t'(st.ph + 2'h1);
      end else begin
        next_st.ph = iesw_pkg::iesw_quad_ph_t'(st.ph - 2'h1);
      end
    end else if (step_i && !st.pend) begin
      next_st.pend = 1'b1;
      next_st.pend_up = dir_i;
    end

    // electrical angle for commutation, wraps per period
    if (st.elec >= per) begin
      next_st.elec = '0;
    end else if (accept && move_up) begin
      next_st.elec = (st.elec == per - `IESW_ELEC_W'(1)) ? '0 : st.elec + `IESW_ELEC_W'(1);
    end else if (accept) begin
      next_st.elec = (st.elec == '0) ? per - `IESW_ELEC_W'(1) : st.elec - `IESW_ELEC_W'(1);
    end

    // incremental outputs from the gray phase
    next_st.incr.a = (next_st.ph == iesw_pkg::IESW_PH1) || (next_st.ph == iesw_pkg::IESW_PH2);
    next_st.incr.b = (next_st.ph == iesw_pkg::IESW_PH2) || (next_st.ph == iesw_pkg::IESW_PH3);
    // reference only in the quarter where both channels are high
    next_st.incr.refp = st.sync2[`IESW_SB_REF] && next_st.incr.a && next_st.incr.b;
    // single-ended variant leaves the complement drivers low
    next_st.incr.a_n = !variant && !next_st.incr.a;
    next_st.incr.b_n = !variant && !next_st.incr.b;
    next_st.incr.refp_n = !variant && !next_st.incr.refp;

    // three tracks 120 electrical degrees apart
    next_st.comm.u = comm_bit(st.elec, '0, per);
    next_st.comm.v = comm_bit(st.elec, per - third, per);
    next_st.comm.w = comm_bit(st.elec, per - third - third, per);
    next_st.comm.u_n = !next_st.comm.u;
    next_st.comm.v_n = !next_st.comm.v;
    next_st.comm.w_n = !next_st.comm.w;

    // fault stretch: a short glitch still gives a full-width pulse
    if (st.sync2[`IESW_SB_FAULT]) begin
      next_st.fault_n = 1'b0;
      next_st.fault_cnt = `IESW_FAULT_W'(FAULT_MIN_CYC - 1);
    end else if (st.fault_cnt != '0) begin
      next_st.fault_n = 1'b0;
      next_st.fault_cnt = st.fault_cnt - `IESW_FAULT_W'(1);
    end else begin
      next_st.fault_n = 1'b1;
    end

    // limit sensors, each bound to one magnet polarity
    next_st.lim1 = st.sync2[`IESW_SB_NORTH];
    next_st.lim2 = st.sync2[`IESW_SB_SOUTH];
  end

  // state register, synchronous active-low reset
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.fault_n <= 1'b1;
      // tracks start at angle zero so no all-low pattern leaks out of reset
      st.comm.u <= 1'b1;
      st.comm.v_n <= 1'b1;
      st.comm.w <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign incr_o = st.incr;
  assign comm_o = st.comm;
  assign fault_detect_n_o = st.fault_n;
  assign first_limit_output_o = st.lim1;
  assign second_limit_output_o = st.lim2;

  // helper: length of the current fault-low stretch
  logic [`IESW_FAULT_W-1:0] low_len;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || st.fault_n) begin
      low_len <= '0;
    end else if (low_len != '1) begin
      low_len <= low_len + `IESW_FAULT_W'(1);
    end
  end

  // helper: cycles since the last channel edge, saturating
  // a counter keeps the spacing check cheap instead of a long repetition
  logic [1:0] ab_prev;
  logic [`IESW_HOLD_W-1:0] gap;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ab_prev <= '0;
      gap <= '1;
    end else begin
      ab_prev <= {st.incr.a, st.incr.b};
      if ({st.incr.a, st.incr.b} != ab_prev) begin
        gap <= '0;
      end else if (gap != '1) begin
        gap <= gap + `IESW_HOLD_W'(1);
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence edge_s;
    $changed({st.incr.a, st.incr.b});
  endsequence

  sequence quiet_s;
    gap >= `IESW_HOLD_W'(EDGE_CYC - 1);
  endsequence

  quad_one_edge_a: assert property (!($changed(st.incr.a) && $changed(st.incr.b)))
    else $error("both channels changed together");

  edge_spacing_a: assert property (edge_s |-> quiet_s)
    else $error("channel edges closer than minimum separation");

  ref_gated_a: assert property (st.incr.refp |-> st.incr.a && st.incr.b)
    else $error("reference pulse outside gate");

  compl_drive_a: assert property (##1 (variant && $stable(variant)) |=>
                                   !st.incr.a_n && !st.incr.b_n && !st.incr.refp_n)
    else $error("complement driven in single-ended variant");

  fwd_b_lags_a: assert property (accept && move_up |=>
    ($rose(st.incr.a) && !st.incr.b) || ($rose(st.incr.b) && st.incr.a) ||
    ($fell(st.incr.a) && st.incr.b) || ($fell(st.incr.b) && !st.incr.a))
    else $error("forward step did not make b lag a");

  fault_low_a: assert property (st.sync2[`IESW_SB_FAULT] |=> !st.fault_n)
    else $error("fault not reported low");

  fault_width_a: assert property ($rose(st.fault_n) |-> $past(low_len) >=
                                   `IESW_FAULT_W'(FAULT_MIN_CYC - 1))
    else $error("fault pulse shorter than minimum");

  comm_tracks_a: assert property (!(st.comm.u && st.comm.v && st.comm.w) &&
                                  (st.comm.u || st.comm.v || st.comm.w) &&
                                  st.comm.u_n == !st.comm.u && st.comm.v_n == !st.comm.v &&
                                  st.comm.w_n == !st.comm.w)
    else $error("commutation tracks inconsistent");

  limit_polarity_a: assert property (st.lim1 == $past(st.sync2[`IESW_SB_NORTH]) &&
                                     st.lim2 == $past(st.sync2[`IESW_SB_SOUTH]))
    else $error("limit output follows wrong magnet");

endmodule // iesw_encoder_out

`default_nettype wire
